// File: hdl/bbacq_reg_bank.v
// APB register bank for baseband acquisition configuration and receive readback
`timescale 1ns/1ps
`include "bbacq_regs.vh"

// Overview of operation
// - Timeline disable bit set means skip long-preamble timeline, treat all preambles short.
// - Diversity metric select: 0 chooses H factors, 1 chooses signal strength.
// - Verify-cycle threshold is a 6-bit 3.3 unsigned value, 0 to 7.875.
// - With adaptation enabled, detect threshold tracks alarms; disabled, it stays programmed.
// - Gating bit 0 acquires on quality detector only; 1 needs energy detect too.
// - Programmed detect threshold drives initial detect and seeds the adaptation logic.
// - Target false alarm rate is N*32 per 2^16 cycles, used only when adapting.
// - Seven-bit long-preamble scrambler seed, top bit unused but writable.
// - Separate short-preamble seed; an outside select bit picks which seed applies.
// - Mux bit 0 returns set b on multiplexed readbacks, 1 returns set a.
// - Test bus readback returns the live test bus in both mux settings.
// - Quality readback: antenna A noise floor in set a, tracking SNR metric in b.
// - Signal field readback: antenna B noise floor in set a, header signal field in b.
// - Length low readback: Q DC offset in set a, length low byte in b.
// - Length high readback: multipath metric in set a, length high byte in b.
// - CRC low readback: multipath count in set a, header CRC low byte in b.
module bbacq_reg_bank #(
  parameter FAR_WINDOW = `BBACQ_FAR_WINDOW
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        clk_en,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        signal_quality_detector,
  input  wire        energy_detect_flag,
  input  wire        false_alarm_event,
  input  wire        preamble_select_control_reg,
  input  wire [7:0]  test_bus,
  input  wire [7:0]  noise_floor_antenna_a,
  input  wire [7:0]  noise_floor_antenna_b,
  input  wire [7:0]  tracking_snr_quality,
  input  wire [7:0]  rx_signal_field,
  input  wire [7:0]  rx_service_field,
  input  wire [15:0] rx_length_field,
  input  wire [7:0]  q_dc_offset,
  input  wire [7:0]  multipath_metric,
  input  wire [7:0]  multipath_count,
  input  wire [15:0] rx_header_crc,
  output reg         long_timeline_enable,
  output reg         diversity_metric_rssi,
  output reg  [5:0]  verify_threshold,
  output reg  [5:0]  detect_threshold,
  output reg         acquisition_trigger,
  output reg  [6:0]  scrambler_seed,
  output reg         all_preambles_short
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  reg  [7:0]                     far_rate;
  reg  [7:0]                     timeline_cfg;
  reg  [7:0]                     threshold_cfg;
  reg  [7:0]                     long_seed;
  reg  [7:0]                     short_seed;
  reg  [5:0]                     adaptive_threshold;
  reg  [`BBACQ_WIN_BITS-1:0]     window_count;
  reg  [`BBACQ_ALARM_BITS-1:0]   alarm_count;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire [7:0]                     reg_index;
  wire                           aligned;
  wire                           access_phase;
  wire                           write_commit;
  wire                           read_set_a;
  wire                           far_disabled;
  wire                           threshold_write;
  wire [`BBACQ_ALARM_BITS-1:0]   alarm_target;
  wire                           window_end;
  reg  [7:0]                     next_rdata;
  reg                            next_mapped;
  reg                            next_writable;
  wire [7:0]                     quality_sel;
  wire [7:0]                     signal_sel;
  wire [7:0]                     length_low_sel;
  wire [7:0]                     length_high_sel;
  wire [7:0]                     crc_low_sel;
  reg  [5:0]                     next_adaptive_threshold;
  reg  [`BBACQ_WIN_BITS-1:0]     next_window_count;
  reg  [`BBACQ_ALARM_BITS-1:0]   next_alarm_count;

  assign reg_index    = paddr[9:2];
  assign aligned      = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign access_phase = psel && penable;
  // Writes land only at the edge where the master sees pready
  assign write_commit = access_phase && pready && pwrite && next_writable;
  assign read_set_a   = short_seed[`BBACQ_BIT_TOP];
  assign far_disabled = threshold_cfg[`BBACQ_BIT_TOP];
  assign threshold_write = write_commit && (reg_index == `BBACQ_IDX_THRESHOLD);
  assign alarm_target = {{(`BBACQ_ALARM_BITS-8-`BBACQ_FAR_SHIFT){1'b0}}, far_rate,
                         {`BBACQ_FAR_SHIFT{1'b0}}};
  assign window_end   = (window_count == FAR_WINDOW - 1);

  // ****************************************************************
  // Readback set selection
  // ****************************************************************
  // Mux bit high picks set a, low picks set b
  // Inputs are sampled live, no capture on read
  assign quality_sel     = read_set_a ? noise_floor_antenna_a : tracking_snr_quality;
  assign signal_sel      = read_set_a ? noise_floor_antenna_b : rx_signal_field;
  assign length_low_sel  = read_set_a ? q_dc_offset : rx_length_field[7:0];
  assign length_high_sel = read_set_a ? multipath_metric : rx_length_field[15:8];
  assign crc_low_sel     = read_set_a ? multipath_count : rx_header_crc[7:0];

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  always @* begin
    next_rdata    = 8'h00;
    next_mapped   = 1'b0;
    next_writable = 1'b0;
    if (aligned) begin
      case (reg_index)
        `BBACQ_IDX_FAR_RATE: begin
          next_rdata    = far_rate;
          next_mapped   = 1'b1;
          next_writable = 1'b1;
        end
        `BBACQ_IDX_TIMELINE: begin
          next_rdata    = timeline_cfg;
          next_mapped   = 1'b1;
          next_writable = 1'b1;
        end
        `BBACQ_IDX_THRESHOLD: begin
          next_rdata    = threshold_cfg;
          next_mapped   = 1'b1;
          next_writable = 1'b1;
        end
        `BBACQ_IDX_LONG_SEED: begin
          next_rdata    = long_seed;
          next_mapped   = 1'b1;
          next_writable = 1'b1;
        end
        `BBACQ_IDX_SHORT_SEED: begin
          next_rdata    = short_seed;
          next_mapped   = 1'b1;
          next_writable = 1'b1;
        end
        `BBACQ_IDX_TEST_BUS: begin
          next_rdata  = test_bus;
          next_mapped = 1'b1;
        end
        `BBACQ_IDX_SIG_QUALITY: begin
          next_rdata  = quality_sel;
          next_mapped = 1'b1;
        end
        `BBACQ_IDX_SIGNAL_FIELD: begin
          next_rdata  = signal_sel;
          next_mapped = 1'b1;
        end
        `BBACQ_IDX_SERVICE_FIELD: begin
          // Same value in both sets
          next_rdata  = rx_service_field;
          next_mapped = 1'b1;
        end
        `BBACQ_IDX_LENGTH_LOW: begin
          next_rdata  = length_low_sel;
          next_mapped = 1'b1;
        end
        `BBACQ_IDX_LENGTH_HIGH: begin
          next_rdata  = length_high_sel;
          next_mapped = 1'b1;
        end
        `BBACQ_IDX_CRC_LOW: begin
          next_rdata  = crc_low_sel;
          next_mapped = 1'b1;
        end
        default: begin
          next_rdata    = 8'h00;
          next_mapped   = 1'b0;
          next_writable = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // APB answer: one wait state, registered response
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (access_phase && !pready) begin
        pready  <= 1'b1;
        pslverr <= !next_mapped;
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  // Read data holds between transfers, cleared by a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en && access_phase && !pready) begin
      // Reads only sample inputs, nothing in the receiver changes
      prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
    end
  end

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      far_rate      <= `BBACQ_RST_FAR_RATE;
      timeline_cfg  <= `BBACQ_RST_TIMELINE;
      threshold_cfg <= `BBACQ_RST_THRESHOLD;
      long_seed     <= `BBACQ_RST_LONG_SEED;
      short_seed    <= `BBACQ_RST_SHORT_SEED;
    end else if (clk_en && write_commit) begin
      // Read-only indexes never reach here
      case (reg_index)
        `BBACQ_IDX_FAR_RATE: begin
          far_rate <= pwdata[7:0];
        end
        `BBACQ_IDX_TIMELINE: begin
          timeline_cfg <= pwdata[7:0];
        end
        `BBACQ_IDX_THRESHOLD: begin
          threshold_cfg <= pwdata[7:0];
        end
        `BBACQ_IDX_LONG_SEED: begin
          long_seed <= pwdata[7:0];
        end
        `BBACQ_IDX_SHORT_SEED: begin
          short_seed <= pwdata[7:0];
        end
        default: begin
          far_rate <= far_rate;
        end
      endcase
    end
  end

  // ****************************************************************
  // False alarm rate adaptation
  // ****************************************************************
  always @* begin
    next_window_count       = window_count;
    next_alarm_count        = alarm_count;
    next_adaptive_threshold = adaptive_threshold;
    if (far_disabled || threshold_write) begin
      // Restart from the programmed value
      next_window_count       = {`BBACQ_WIN_BITS{1'b0}};
      next_alarm_count        = {`BBACQ_ALARM_BITS{1'b0}};
      next_adaptive_threshold = threshold_write ? pwdata[`BBACQ_THR_MSB:0]
                                                : threshold_cfg[`BBACQ_THR_MSB:0];
    end else if (window_end) begin
      next_window_count = {`BBACQ_WIN_BITS{1'b0}};
      next_alarm_count  = {`BBACQ_ALARM_BITS{1'b0}};
      // Too many alarms raises the threshold, too few lowers it
      if (alarm_count > alarm_target) begin
        if (adaptive_threshold != `BBACQ_THR_MAX) begin
          next_adaptive_threshold = adaptive_threshold + 6'h01;
        end
      end else if (alarm_count < alarm_target) begin
        if (adaptive_threshold != `BBACQ_THR_MIN) begin
          next_adaptive_threshold = adaptive_threshold - 6'h01;
        end
      end
    end else begin
      next_window_count = window_count + {{(`BBACQ_WIN_BITS-1){1'b0}}, 1'b1};
      // Saturate so a stuck alarm cannot wrap the count
      if (false_alarm_event && (alarm_count != {`BBACQ_ALARM_BITS{1'b1}})) begin
        next_alarm_count = alarm_count + {{(`BBACQ_ALARM_BITS-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window_count       <= {`BBACQ_WIN_BITS{1'b0}};
      alarm_count        <= {`BBACQ_ALARM_BITS{1'b0}};
      adaptive_threshold <= `BBACQ_THR_MIN;
    end else if (clk_en) begin
      window_count       <= next_window_count;
      alarm_count        <= next_alarm_count;
      adaptive_threshold <= next_adaptive_threshold;
    end
  end

  // ****************************************************************
  // Receiver controls
  // ****************************************************************
  // Each control lags its register or input by one enabled cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_timeline_enable <= 1'b0;
    end else if (clk_en) begin
      long_timeline_enable <= !timeline_cfg[`BBACQ_BIT_TOP];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      all_preambles_short <= 1'b0;
    end else if (clk_en) begin
      all_preambles_short <= timeline_cfg[`BBACQ_BIT_TOP];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diversity_metric_rssi <= 1'b0;
    end else if (clk_en) begin
      diversity_metric_rssi <= timeline_cfg[`BBACQ_BIT_SEL];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      verify_threshold <= `BBACQ_THR_MIN;
    end else if (clk_en) begin
      verify_threshold <= timeline_cfg[`BBACQ_THR_MSB:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_threshold <= `BBACQ_THR_MIN;
    end else if (clk_en) begin
      detect_threshold <= far_disabled ? threshold_cfg[`BBACQ_THR_MSB:0]
                                       : adaptive_threshold;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acquisition_trigger <= 1'b0;
    end else if (clk_en) begin
      acquisition_trigger <= signal_quality_detector &&
                             (!threshold_cfg[`BBACQ_BIT_SEL] || energy_detect_flag);
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scrambler_seed <= 7'h00;
    end else if (clk_en) begin
      scrambler_seed <= preamble_select_control_reg ? short_seed[`BBACQ_SEED_MSB:0]
                                                    : long_seed[`BBACQ_SEED_MSB:0];
    end
  end

endmodule // bbacq_reg_bank

// File: hdl/bbacq_regs.vh
// Register indexes, field positions, reset values and timing for the acquisition register bank
`ifndef BBACQ_REGS_VH
`define BBACQ_REGS_VH

// ****************************************************************
// Register indexes (byte address = 4 * index)
// ****************************************************************
`define BBACQ_IDX_FAR_RATE      8'h5a
`define BBACQ_IDX_TIMELINE      8'h5c
`define BBACQ_IDX_THRESHOLD     8'h5e
`define BBACQ_IDX_LONG_SEED     8'h60
`define BBACQ_IDX_SHORT_SEED    8'h62
`define BBACQ_IDX_TEST_BUS      8'h64
`define BBACQ_IDX_SIG_QUALITY   8'h66
`define BBACQ_IDX_SIGNAL_FIELD  8'h68
`define BBACQ_IDX_SERVICE_FIELD 8'h6a
`define BBACQ_IDX_LENGTH_LOW    8'h6c
`define BBACQ_IDX_LENGTH_HIGH   8'h6e
`define BBACQ_IDX_CRC_LOW       8'h70

// ****************************************************************
// Field positions
// ****************************************************************
`define BBACQ_BIT_TOP           7
`define BBACQ_BIT_SEL           6
`define BBACQ_THR_MSB           5
`define BBACQ_SEED_MSB          6
`define BBACQ_FAR_SHIFT         5

// ****************************************************************
// Reset values
// ****************************************************************
`define BBACQ_RST_FAR_RATE      8'h00
`define BBACQ_RST_TIMELINE      8'h00
`define BBACQ_RST_THRESHOLD     8'h00
`define BBACQ_RST_LONG_SEED     8'h00
`define BBACQ_RST_SHORT_SEED    8'h00
`define BBACQ_THR_MAX           6'h3f
`define BBACQ_THR_MIN           6'h00

// ****************************************************************
// Timing
// ****************************************************************
`define BBACQ_FAR_WINDOW        65536
`define BBACQ_WIN_BITS          17
`define BBACQ_ALARM_BITS        16

`endif

// File: verification/bbacq_reg_bank_assertions.sv
// Port assertions for the acquisition register bank
`timescale 1ns/1ps
`include "bbacq_regs.vh"
module bbacq_reg_bank_assertions (
  input wire        pclk,
  input wire        presetn,
  input wire        clk_en,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        signal_quality_detector,
  input wire [7:0]  test_bus,
  input wire        long_timeline_enable,
  input wire        acquisition_trigger,
  input wire        all_preambles_short
);
  // ****************************************************************
  // Address decode and sequences
  // ****************************************************************
  wire [7:0] idx     = paddr[9:2];
  wire       bad_adr = (paddr[1:0] != 2'b00) || (paddr[11:10] != 2'b00) || idx[0] ||
                       (idx < `BBACQ_IDX_FAR_RATE) || (idx > `BBACQ_IDX_CRC_LOW);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence access_wait;
    psel && penable && !pready && clk_en;
  endsequence
  sequence answer_due;
    pready || !clk_en;
  endsequence
  // ****************************************************************
  // Properties
  // ****************************************************************
  ready_timing_a: assert property (access_wait |=> answer_due)
    else $error("pready late");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held high");
  err_decode_a: assert property (pready |-> pslverr == bad_adr)
    else $error("pslverr does not match address");
  err_data_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("refused transfer returned data");
  upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("prdata upper bits set");
  data_hold_a: assert property (!pready && $past(presetn) |-> $stable(prdata))
    else $error("prdata changed between transfers");
  bus_live_a: assert property (pready && !pwrite && !pslverr &&
    idx == `BBACQ_IDX_TEST_BUS |-> prdata[7:0] == $past(test_bus))
    else $error("test bus readback wrong");
  preamble_mode_a: assert property ($past(presetn) |->
    all_preambles_short != long_timeline_enable)
    else $error("preamble mode outputs agree");
  trigger_cause_a: assert property (acquisition_trigger && $past(presetn) && $past(clk_en) |->
    $past(signal_quality_detector))
    else $error("trigger without quality detect");
endmodule // bbacq_reg_bank_assertions

bind bbacq_reg_bank bbacq_reg_bank_assertions bbacq_reg_bank_assertions_i (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .signal_quality_detector(signal_quality_detector), .test_bus(test_bus),
  .long_timeline_enable(long_timeline_enable), .acquisition_trigger(acquisition_trigger),
  .all_preambles_short(all_preambles_short)
);

// File: verification/tb_top.sv
// Self-checking bench for the acquisition register bank
`timescale 1ns/1ps
`include "bbacq_regs.vh"
module tb_top;
  // ****************************************************************
  // Signals and design
  // ****************************************************************
  logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        pready, pslverr, sq = 0, ed = 0, fa = 0, psc = 0;
  logic [7:0]  tbus = 0, nfa = 0, nfb = 0, tsnr = 0, sigf = 0, svc = 0, qdc = 0, mpm = 0, mpc = 0;
  logic [15:0] len = 0, crc = 0;
  logic        lte, dms, trig, aps;
  logic [5:0]  vthr, dthr;
  logic [6:0]  seed;
  logic [32:0] exq[$];
  logic [7:0]  rw_ix[5] = '{`BBACQ_IDX_FAR_RATE, `BBACQ_IDX_TIMELINE, `BBACQ_IDX_THRESHOLD,
                            `BBACQ_IDX_LONG_SEED, `BBACQ_IDX_SHORT_SEED};
  logic [7:0]  rw_v[5];
  int          fails = 0, checks_done = 0;
  always #2 pclk = ~pclk;
  bbacq_reg_bank #(.FAR_WINDOW(64)) bbacq_reg_bank_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .signal_quality_detector(sq), .energy_detect_flag(ed),
    .false_alarm_event(fa), .preamble_select_control_reg(psc), .test_bus(tbus),
    .noise_floor_antenna_a(nfa), .noise_floor_antenna_b(nfb), .tracking_snr_quality(tsnr),
    .rx_signal_field(sigf), .rx_service_field(svc), .rx_length_field(len),
    .q_dc_offset(qdc), .multipath_metric(mpm), .multipath_count(mpc), .rx_header_crc(crc),
    .long_timeline_enable(lte), .diversity_metric_rssi(dms), .verify_threshold(vthr),
    .detect_threshold(dthr), .acquisition_trigger(trig), .scrambler_seed(seed),
    .all_preambles_short(aps));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task chk(input string nm, input [32:0] e, input [32:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task apb(input logic w, input [11:0] a, input [7:0] d, input [32:0] ex);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {24'h00_0000, d};
    exq.push_back(ex);
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) fails++;
    psel <= 0; penable <= 0;
  endtask
  task wr(input [7:0] ix, input [7:0] d);
    apb(1, {2'b00, ix, 2'b00}, d, 33'h0_0000_0000);
  endtask
  task rd(input [7:0] ix, input [7:0] v);
    apb(0, {2'b00, ix, 2'b00}, 8'h00, {25'h000_0000, v});
  endtask
  task settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask
  // ****************************************************************
  // Bus result monitor
  // ****************************************************************
  always @(posedge pclk)
    if (pready === 1'b1 && exq.size() > 0)
      chk("apb", exq.pop_front(), {pslverr, prdata});
  initial begin
    #120000;
    fails++;
    end_sim;
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    void'($urandom(73));
    repeat (5) @(posedge pclk);
    #1 chk("reset_lte", 0, lte);
    repeat (5) @(posedge pclk);
    presetn <= 1;
    settle;
    chk("lte_after_reset", 1, lte);
    foreach (rw_ix[i]) begin
      rw_v[i] = $urandom;
      wr(rw_ix[i], rw_v[i]);
      rd(rw_ix[i], rw_v[i]);
    end
    wr(`BBACQ_IDX_TIMELINE, 8'hc5);
    settle;
    chk("tl_c5", {1'b1, 1'b0, 1'b1, 6'h05}, {aps, lte, dms, vthr});
    wr(`BBACQ_IDX_TIMELINE, 8'h3f);
    settle;
    chk("tl_3f", {1'b0, 1'b1, 1'b0, 6'h3f}, {aps, lte, dms, vthr});
    wr(`BBACQ_IDX_THRESHOLD, 8'hea);
    sq <= 1;
    settle;
    chk("gate_ed_low", {1'b0, 6'h2a}, {trig, dthr});
    ed <= 1;
    settle;
    chk("gate_ed_high", 1, trig);
    wr(`BBACQ_IDX_THRESHOLD, 8'haa);
    ed <= 0;
    settle;
    chk("gate_sq_only", 1, trig);
    wr(`BBACQ_IDX_LONG_SEED, 8'h55);
    wr(`BBACQ_IDX_SHORT_SEED, 8'h2b);
    psc <= 1;
    settle;
    chk("seed_short", 7'h2b, seed);
    psc <= 0;
    settle;
    chk("seed_long", 7'h55, seed);
    wr(`BBACQ_IDX_FAR_RATE, 8'h01);
    wr(`BBACQ_IDX_THRESHOLD, 8'h10);
    settle;
    chk("far_start", 6'h10, dthr);
    fa <= 1;
    repeat (224) @(posedge pclk);
    #1 chk("far_rise", 1, dthr >= 6'h12 && dthr <= 6'h14);
    fa <= 0;
    clk_en <= 0;
    sq <= 0;
    settle;
    chk("trig_frozen", 1, trig);
    clk_en <= 1;
    settle;
    chk("trig_released", 0, trig);
    for (int m = 0; m < 2; m++) begin
      wr(`BBACQ_IDX_SHORT_SEED, {m[0], 7'h2b});
      {tbus, nfa, nfb, tsnr, sigf, svc, qdc, mpm} <= {$urandom, $urandom};
      {mpc, len, crc} <= {$urandom, $urandom};
      @(posedge pclk);
      rd(`BBACQ_IDX_TEST_BUS, tbus);
      rd(`BBACQ_IDX_SIG_QUALITY, m ? nfa : tsnr);
      rd(`BBACQ_IDX_SIGNAL_FIELD, m ? nfb : sigf);
      rd(`BBACQ_IDX_SERVICE_FIELD, svc);
      rd(`BBACQ_IDX_LENGTH_LOW, m ? qdc : len[7:0]);
      rd(`BBACQ_IDX_LENGTH_HIGH, m ? mpm : len[15:8]);
      rd(`BBACQ_IDX_CRC_LOW, m ? mpc : crc[7:0]);
    end
    wr(`BBACQ_IDX_SIG_QUALITY, ~nfa);
    rd(`BBACQ_IDX_SIG_QUALITY, nfa);
    apb(0, 12'h000, 8'h00, {1'b1, 32'h0000_0000});
    apb(1, 12'h179, 8'h77, {1'b1, 32'h0000_0000});
    rd(`BBACQ_IDX_LONG_SEED, 8'h55);
    settle;
    end_sim;
  end
endmodule // tb_top
